// ---- design/imc_pkg.sv ----
// Shared constants and types for the two-wire bus controller
package imc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_OWN_ADDR = 8'hE0;
    localparam logic [7:0] IDX_DIVIDER  = 8'hE1;
    localparam logic [7:0] IDX_CONTROL  = 8'hE2;
    localparam logic [7:0] IDX_STATUS   = 8'hE3;
    localparam logic [7:0] IDX_DATA     = 8'hE4;
    localparam logic [7:0] IDX_PORT     = 8'hE6;
    localparam logic [7:0] IDX_PORT_DIR = 8'hE7;
    // Control bit positions
    localparam int CTL_ENABLE = 7;
    localparam int CTL_IE     = 6;
    localparam int CTL_MS     = 5;
    localparam int CTL_TX     = 4;
    localparam int CTL_NOACK  = 3;
    localparam int CTL_REPEATED_START_REQUEST   = 2;
    // Status bit positions
    localparam int ST_TCF  = 7;
    localparam int ST_ADDRESSED_AS_SLAVE_FLAG = 6;
    localparam int ST_BUSY = 5;
    localparam int ST_AL   = 4;
    localparam int ST_SRW  = 2;
    localparam int ST_IF   = 1;
    localparam int ST_RECEIVED_ACK_FLAG = 0;
    // Reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] REG8_RST    = 8'h00;
    localparam logic       TCF_RST     = 1'b1;
    // Timing counts in quarter-bit ticks, then bit counter values for the ack and last bit
    localparam logic [2:0] PHASE_TICKS = 3'h2;
    localparam logic [2:0] FREE_TICKS  = 3'h4;
    localparam logic [3:0] ACK_BIT     = 4'h8;
    localparam logic [3:0] LAST_BIT    = 4'h9;
    // Master clock generator states
    typedef enum logic [5:0] {
        MG_IDLE   = 6'h01,
        MG_FREE   = 6'h02,
        MG_START  = 6'h04,
        MG_CLOCK  = 6'h08,
        MG_RSTART = 6'h10,
        MG_STOP   = 6'h20
    } imc_mg_type;
    // Clock line in bit 1, data line in bit 0
    typedef struct packed {
        logic scl;
        logic sda;
    } imc_pin_type;
endpackage

// ---- design/imc_controller.sv ----
// Two-wire bus master/slave controller with AHB-Lite register slave
`timescale 1ns/1ps
// Overview of operation
// - Port pins 7:6 are inputs with direction 0, outputs with 1, when disabled.
// - Direction bits 5:0 are plain readable and writable storage.
// - Start logic waits a bus free time after a stop.
// - Setting master and transmit bits together starts a master transmit.
// - Status shows bus busy, pending interrupt and received acknowledge.
// - Byte end sets transfer complete and interrupt flag, raises enabled interrupt.
// - Data read in receive or write in transmit clears transfer complete.
// - Address cycle ends in transmit mode; software switches to receive.
// - Slave direction flag is valid only at the address-match interrupt.
// - Clearing master select generates a stop condition.
// - Repeated start bit as master makes a start without a stop.
// - Control write clears addressed-as-slave; set only at matched address end.
// - Slave holds clock low between bytes until the data access.
// - Arbitration loss drops to slave receive, clocks to byte end, interrupts.
// - Start while bus busy clears master without stop, flags loss.
// - Master select rising starts master mode, falling stops it.
// - Arbitration lost and interrupt flags stay until written with one.
module imc_controller (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    // Serial lines, open drain when enabled; driven as general port pins when disabled
    input  wire imc_pkg::imc_pin_type pin_in,
    output imc_pkg::imc_pin_type     pin_out,
    output imc_pkg::imc_pin_type     pin_oe,
    // Interrupt request
    output logic                     irq
);
    logic [7:0]          own_addr, divider, control, port_data, port_ib_direction, data_reg;
    logic                transfer_complete_flag, addressed_as_slave_flag, busy, al, slave_direction_flag, pending_interrupt_flag, received_ack_flag, hold, repeated_start_request_pend;
    logic                scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
    logic [3:0]          bitcnt;
    logic                addr_phase, slave_sel, lost_keep, mg_scl_low, mg_sda_low;
    logic [7:0]          shift_in;
    logic [9:0]          tick_cnt;
    logic [2:0]          step;
    imc_pkg::imc_mg_type mg_state;
    logic                ap_valid, ap_write;
    logic [7:0]          ap_idx;
    logic                next_eng_low;

    wire ms     = control[imc_pkg::CTL_MS];
    wire tx     = control[imc_pkg::CTL_TX];
    wire enable = control[imc_pkg::CTL_ENABLE];
    wire [7:0] wdata   = hwdata[7:0];
    wire addr_take     = hsel & hready & htrans[1];
    wire rd_take       = addr_take & ~hwrite;
    wire wr_en         = ap_valid & ap_write;
    wire ctl_wr        = wr_en & (ap_idx == imc_pkg::IDX_CONTROL);
    wire st_wr         = wr_en & (ap_idx == imc_pkg::IDX_STATUS);
    wire data_wr       = wr_en & (ap_idx == imc_pkg::IDX_DATA);
    wire data_rd       = rd_take & (haddr[9:2] == imc_pkg::IDX_DATA);
    wire rise          = scl_s & ~scl_q;
    wire fall          = ~scl_s & scl_q;
    wire start_det     = enable & scl_s & scl_q & sda_q & ~sda_s;
    wire stop_det      = enable & scl_s & scl_q & ~sda_q & sda_s;
    wire tick          = (tick_cnt == 10'h000);
    wire match         = enable & (shift_in[7:1] == own_addr[7:1]);
    wire part          = ms | slave_sel;
    wire byte_end      = enable & fall & (bitcnt == imc_pkg::LAST_BIT);
    wire addr_hit      = byte_end & addr_phase & match & ~ms;
    wire evt_byte      = byte_end & (part | lost_keep | addr_hit);
    wire tx_drv        = tx & part & ~(addr_phase & ~ms);
    wire want_high     = (bitcnt < imc_pkg::ACK_BIT) ? (tx & data_reg[3'h7 - bitcnt[2:0]])
                       : ((bitcnt == imc_pkg::ACK_BIT) & ~tx & control[imc_pkg::CTL_NOACK]);
    wire arb_lost_bit  = rise & ms & (mg_state == imc_pkg::MG_CLOCK) & want_high & ~sda_s;
    wire ms_set_wr     = ctl_wr & ~ms & wdata[imc_pkg::CTL_MS];
    wire lost_start    = (ms_set_wr & busy)
                       | (tick & (mg_state == imc_pkg::MG_FREE) & busy);
    wire lost_repeated_start_request     = ctl_wr & wdata[imc_pkg::CTL_REPEATED_START_REQUEST] & ~ms & enable;
    wire lost_stop     = stop_det & ms & (mg_state != imc_pkg::MG_STOP);
    wire lost          = arb_lost_bit | lost_start | lost_repeated_start_request | lost_stop;

    function automatic logic [7:0] read_reg(input logic [7:0] idx);
        case (idx)
            imc_pkg::IDX_OWN_ADDR: read_reg = own_addr;
            imc_pkg::IDX_DIVIDER:  read_reg = divider;
            imc_pkg::IDX_CONTROL:  read_reg = {control[7:3], 3'h0};
            imc_pkg::IDX_STATUS:   read_reg = {transfer_complete_flag, addressed_as_slave_flag, busy, al, 1'b0, slave_direction_flag, pending_interrupt_flag, received_ack_flag};
            imc_pkg::IDX_DATA:     read_reg = data_reg;
            // Bits without pins read as pulled-up ones when inputs
            imc_pkg::IDX_PORT:     read_reg = (port_ib_direction & port_data)
                                            | (~port_ib_direction & {scl_s, sda_s, 6'h3F});
            imc_pkg::IDX_PORT_DIR: read_reg = port_ib_direction;
            default:               read_reg = 8'h00;
        endcase
    endfunction

    // Bus slave: zero wait states, read data registered in the address phase
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ap_valid  <= 1'b0;
            ap_write  <= 1'b0;
            ap_idx    <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            ap_valid  <= addr_take;
            ap_write  <= hwrite;
            ap_idx    <= haddr[9:2];
            hrdata    <= rd_take ? {24'h00_0000, read_reg(haddr[9:2])} : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Plain storage registers
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            own_addr          <= imc_pkg::REG8_RST;
            divider           <= imc_pkg::REG8_RST;
            port_data         <= imc_pkg::REG8_RST;
            port_ib_direction <= imc_pkg::REG8_RST;
        end
        else if (wr_en)
        begin
            if (ap_idx == imc_pkg::IDX_OWN_ADDR) own_addr <= wdata;
            if (ap_idx == imc_pkg::IDX_DIVIDER) divider <= wdata;
            if (ap_idx == imc_pkg::IDX_PORT) port_data <= wdata;
            if (ap_idx == imc_pkg::IDX_PORT_DIR) port_ib_direction <= wdata;
        end
    end

    // Control register; hardware drops master on any loss, transmit only on a lost bit
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            control   <= imc_pkg::CONTROL_RST;
            repeated_start_request_pend <= 1'b0;
        end
        else
        begin
            if (ctl_wr)
                control <= {wdata[7:6], wdata[5] & ~(~ms & busy), wdata[4:3], 3'h0};
            if (lost)
                control[imc_pkg::CTL_MS] <= 1'b0;
            if (arb_lost_bit)
                control[imc_pkg::CTL_TX] <= 1'b0;
            if (ctl_wr & wdata[imc_pkg::CTL_REPEATED_START_REQUEST] & ms)
                repeated_start_request_pend <= 1'b1;
            else if (mg_state == imc_pkg::MG_RSTART || !ms)
                repeated_start_request_pend <= 1'b0;
        end
    end

    // Line synchronisers and edge history
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            {scl_m, scl_s, scl_q} <= 3'h7;
            {sda_m, sda_s, sda_q} <= 3'h7;
        end
        else
        begin
            {scl_m, scl_s, scl_q} <= {pin_in.scl, scl_m, scl_s};
            {sda_m, sda_s, sda_q} <= {pin_in.sda, sda_m, sda_s};
        end
    end

    // Byte engine follows the observed clock in both roles
    always_ff @(posedge clk_sys)
    begin
        if (rst || !enable)
        begin
            bitcnt     <= 4'h0;
            addr_phase <= 1'b0;
            slave_sel  <= 1'b0;
            shift_in   <= 8'h00;
        end
        else if (start_det || stop_det)
        begin
            bitcnt     <= 4'h0;
            addr_phase <= start_det;
            slave_sel  <= 1'b0;
        end
        else if (rise && bitcnt != imc_pkg::LAST_BIT)
        begin
            if (bitcnt < imc_pkg::ACK_BIT)
                shift_in <= {shift_in[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
        end
        else if (byte_end)
        begin
            bitcnt     <= 4'h0;
            addr_phase <= 1'b0;
            if (addr_hit)
                slave_sel <= 1'b1;
        end
    end

    // Data line value the engine wants while the clock is low
    always_comb
    begin
        next_eng_low = 1'b0;
        if (bitcnt < imc_pkg::ACK_BIT)
            next_eng_low = tx_drv & ~data_reg[3'h7 - bitcnt[2:0]];
        else if (bitcnt == imc_pkg::ACK_BIT)
            next_eng_low = (addr_phase & ~ms) ? match
                         : (~tx & part & ~control[imc_pkg::CTL_NOACK]);
    end

    // Status flags; a hardware set always beats a software clear
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            transfer_complete_flag  <= imc_pkg::TCF_RST;
            {addressed_as_slave_flag, busy, al, slave_direction_flag, pending_interrupt_flag, received_ack_flag, hold} <= 7'h00;
            data_reg <= imc_pkg::REG8_RST;
        end
        else
        begin
            if (evt_byte)
                transfer_complete_flag <= 1'b1;
            else if ((data_wr && tx) || (data_rd && !tx))
                transfer_complete_flag <= 1'b0;
            if (evt_byte || lost)
                pending_interrupt_flag <= 1'b1;
            else if (st_wr && wdata[imc_pkg::ST_IF])
                pending_interrupt_flag <= 1'b0;
            if (lost)
                al <= 1'b1;
            else if (st_wr && wdata[imc_pkg::ST_AL])
                al <= 1'b0;
            if (addr_hit)
                addressed_as_slave_flag <= 1'b1;
            else if (ctl_wr || evt_byte)
                addressed_as_slave_flag <= 1'b0;
            if (addr_hit)
                slave_direction_flag <= shift_in[0];
            if (rise && bitcnt == imc_pkg::ACK_BIT && part)
                received_ack_flag <= sda_s;
            if (start_det)
                busy <= 1'b1;
            else if (stop_det || !enable)
                busy <= 1'b0;
            // Master holds from its start request, so an early address write is not lost
            if ((evt_byte && !lost_keep) || (ms_set_wr && !busy)
                || (ctl_wr && wdata[imc_pkg::CTL_REPEATED_START_REQUEST] && ms))
                hold <= 1'b1;
            else if ((data_wr && tx) || (data_rd && !tx) || (start_det && !ms) || stop_det
                     || !enable || (ctl_wr && ms && !wdata[imc_pkg::CTL_MS]))
                hold <= 1'b0;
            if (data_wr)
                data_reg <= wdata;
            else if (byte_end)
                data_reg <= shift_in;
        end
    end

    // Quarter-bit tick from the divider
    always_ff @(posedge clk_sys)
    begin
        if (rst || tick)
            tick_cnt <= rst ? 10'h000 : {divider, 2'h3};
        else
            tick_cnt <= tick_cnt - 10'h001;
    end

    // Master clock, start, repeated start and stop generator
    always_ff @(posedge clk_sys)
    begin
        if (rst || !enable)
        begin
            mg_state   <= imc_pkg::MG_IDLE;
            step       <= 3'h0;
            mg_scl_low <= 1'b0;
            mg_sda_low <= 1'b0;
            lost_keep  <= 1'b0;
        end
        else
        begin
            if (arb_lost_bit)
                lost_keep <= 1'b1;
            case (mg_state)
                imc_pkg::MG_IDLE:
                begin
                    mg_scl_low <= 1'b0;
                    mg_sda_low <= 1'b0;
                    step       <= 3'h0;
                    if (ms)
                        mg_state <= imc_pkg::MG_FREE;
                end
                imc_pkg::MG_FREE:
                    if (!ms || lost_start)
                        mg_state <= imc_pkg::MG_IDLE;
                    else if (tick)
                    begin
                        step <= step + 3'h1;
                        if (step == imc_pkg::FREE_TICKS - 3'h1)
                        begin
                            mg_state   <= imc_pkg::MG_START;
                            mg_sda_low <= 1'b1;
                            step       <= 3'h0;
                        end
                    end
                imc_pkg::MG_START:
                    if (tick)
                    begin
                        step <= step + 3'h1;
                        if (step == imc_pkg::PHASE_TICKS - 3'h1)
                        begin
                            mg_state   <= imc_pkg::MG_CLOCK;
                            mg_scl_low <= 1'b1;
                            step       <= 3'h0;
                        end
                    end
                imc_pkg::MG_CLOCK:
                    if (byte_end && lost_keep)
                    begin
                        lost_keep  <= 1'b0;
                        mg_state   <= imc_pkg::MG_IDLE;
                    end
                    else if (!mg_scl_low)
                    begin
                        // Stretching: high time counts only once the line is seen high
                        if (tick && scl_s)
                            step <= step + 3'h1;
                        if (tick && scl_s && step == imc_pkg::PHASE_TICKS - 3'h1)
                        begin
                            mg_scl_low <= 1'b1;
                            step       <= 3'h0;
                        end
                    end
                    else if (tick)
                    begin
                        if (step != imc_pkg::PHASE_TICKS - 3'h1)
                            step <= step + 3'h1;
                        else if (lost_keep || (ms && !hold && !repeated_start_request_pend))
                        begin
                            mg_scl_low <= 1'b0;
                            step       <= 3'h0;
                        end
                        else if (!ms)
                        begin
                            mg_state   <= imc_pkg::MG_STOP;
                            step       <= 3'h0;
                        end
                        else if (repeated_start_request_pend)
                        begin
                            mg_state   <= imc_pkg::MG_RSTART;
                            step       <= 3'h0;
                        end
                    end
                imc_pkg::MG_RSTART:
                    if (tick && (step != 3'h2 || scl_s))
                    begin
                        step <= step + 3'h1;
                        case (step)
                            3'h0:    mg_sda_low <= 1'b0;
                            3'h1:    mg_scl_low <= 1'b0;
                            3'h2:    mg_sda_low <= 1'b1;
                            default:
                            begin
                                mg_scl_low <= 1'b1;
                                mg_state   <= imc_pkg::MG_CLOCK;
                                step       <= 3'h0;
                            end
                        endcase
                    end
                imc_pkg::MG_STOP:
                    if (tick && (step != 3'h2 || scl_s))
                    begin
                        step <= step + 3'h1;
                        case (step)
                            3'h0:    mg_sda_low <= 1'b1;
                            3'h1:    mg_scl_low <= 1'b0;
                            3'h2:    mg_sda_low <= 1'b0;
                            default: mg_state   <= imc_pkg::MG_IDLE;
                        endcase
                    end
                default:
                    mg_state <= imc_pkg::MG_IDLE;
            endcase
        end
    end

    wire mg_sda_ctl = (mg_state == imc_pkg::MG_START) || (mg_state == imc_pkg::MG_RSTART)
                   || (mg_state == imc_pkg::MG_STOP);

    // Pin drivers; the shared pins fall back to the general port when disabled
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin_out <= 2'h0;
            pin_oe  <= 2'h0;
            irq     <= 1'b0;
        end
        else
        begin
            irq <= pending_interrupt_flag & control[imc_pkg::CTL_IE];
            if (!enable)
            begin
                pin_out <= port_data[7:6];
                pin_oe  <= port_ib_direction[7:6];
            end
            else
            begin
                pin_out    <= 2'h0;
                pin_oe.scl <= mg_scl_low | (hold & ~ms);
                if (mg_sda_ctl)
                    pin_oe.sda <= mg_sda_low;
                else if (!scl_s)
                    pin_oe.sda <= next_eng_low;
            end
        end
    end

    gpio_dir_a: assert property (@(posedge clk_sys) disable iff (rst)
        !enable |=> (pin_oe.sda == $past(port_ib_direction[6])))
        else $error("port pin direction not followed");
    byte_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
        evt_byte |=> (transfer_complete_flag && pending_interrupt_flag))
        else $error("byte end flags missing");
    tcf_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        (data_wr && tx && !evt_byte) |=> !transfer_complete_flag)
        else $error("transfer complete not cleared");
    busy_start_a: assert property (@(posedge clk_sys) disable iff (rst)
        (ms_set_wr && busy) |=> (!ms && al && pending_interrupt_flag))
        else $error("start on busy bus not refused");
    addressed_as_slave_flag_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        (ctl_wr && !addr_hit) |=> !addressed_as_slave_flag)
        else $error("slave flag survived control write");
    arb_drop_a: assert property (@(posedge clk_sys) disable iff (rst)
        arb_lost_bit |=> (!ms && !tx && al) ##1 !pin_oe.sda)
        else $error("arbitration loss not handled");
    busy_set_a: assert property (@(posedge clk_sys) disable iff (rst)
        start_det |=> busy [*2])
        else $error("bus busy not set on start");
    slave_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        (enable && hold && !ms) |=> pin_oe.scl)
        else $error("slave clock not held");
    flag_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
        (al && !(st_wr && wdata[imc_pkg::ST_AL])) |=> al)
        else $error("arbitration flag lost");
    rstart_src_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(mg_state == imc_pkg::MG_RSTART) |-> $past(repeated_start_request_pend))
        else $error("repeated start without request");
endmodule

// ---- design/imc_controller_unused.sv ----
// Intentionally empty
`timescale 1ns/1ps

// ---- testbench/imc_slave_model.sv ----
// Slave model on the two-wire bus that acknowledges its own address
`timescale 1ns/1ps
module imc_slave_model #(
    parameter logic [6:0] ADDR    = 7'h2A,
    parameter int         STRETCH = 300
) (
    // Wire levels and pull-down enables
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_oe = 1'b0,
    output logic      sda_oe = 1'b0
);
    int         cnt = 0;
    logic       on  = 1'b0;
    logic [7:0] sr  = 8'h00;
    // Start seen: restart the bit count
    always @(negedge sda)
        if (scl)
        begin
            // The start's own clock fall is not a data bit
            cnt = -1;
            on = 1'b1;
        end
    always @(posedge scl)
        if (on && cnt < 8)
            sr = {sr[6:0], sda};
    // Ack after bit eight; a slow reply stretches the clock after bit nine
    always @(negedge scl)
        if (on)
        begin
            cnt = cnt + 1;
            sda_oe = (cnt == 8) && (sr[7:1] == ADDR);
            if (cnt == 9)
            begin
                on = 1'b0;
                scl_oe = 1'b1;
                #STRETCH scl_oe = 1'b0;
            end
        end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench: register access and master address transfers
`timescale 1ns/1ps
module testbench;
    localparam logic [6:0] SA = 7'h2A;
    logic                 clk_sys = 1'b0;
    logic                 rst = 1'b1;
    logic [31:0]          haddr = 32'h0;
    logic [1:0]           htrans = 2'b00;
    logic                 hwrite = 1'b0;
    logic [31:0]          hwdata = 32'h0;
    logic                 hrdy;
    logic [31:0]          hrdata;
    logic                 irq;
    logic                 scl_pd;
    logic                 sda_pd;
    imc_pkg::imc_pin_type po;
    imc_pkg::imc_pin_type pe;
    wire                  scl = (pe.scl ? po.scl : 1'b1) & ~scl_pd;
    wire                  sda = (pe.sda ? po.sda : 1'b1) & ~sda_pd;
    int                   fail_count = 0;
    int                   num_checks = 0;
    integer               seed = 32'hC45B1959;
    logic [7:0]           rd;
    logic [7:0]           v;
    logic [7:0]           nak;
    imc_controller dut (.clk_sys(clk_sys), .rst(rst), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hreadyout(hrdy), .hresp(), .hrdata(hrdata), .pin_in({scl, sda}), .pin_out(po),
        .pin_oe(pe), .irq(irq));
    imc_slave_model #(.ADDR(SA), .STRETCH(300)) partner (.scl(scl), .sda(sda),
        .scl_oe(scl_pd), .sda_oe(sda_pd));
    initial
        forever #4 clk_sys = ~clk_sys;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk_sys); while (hrdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge clk_sys); while (hrdy !== 1'b1);
        rd = hrdata[7:0];
    endtask
    // Poll status under a bounded count; a timeout shows in the next compare
    task automatic wait_st(input int b, input logic lvl);
        rd[b] = ~lvl;
        for (int i = 0; i < 3000 && rd[b] !== lvl; i++)
            bus(1'b0, imc_pkg::IDX_STATUS, 8'h00);
    endtask
    task automatic stop_test;
        if (fail_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #400000;
        fail_count++;
        stop_test();
    end
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        bus(1'b0, imc_pkg::IDX_STATUS, 8'h00);
        chk(rd, 8'h80);
        // Port data high first, so driven pins never pull the lines low
        bus(1'b1, imc_pkg::IDX_PORT, 8'hC0);
        repeat (4)
        begin
            v = 8'($random(seed));
            bus(1'b1, imc_pkg::IDX_PORT_DIR, v);
            bus(1'b0, imc_pkg::IDX_PORT_DIR, 8'h00);
            chk(rd, v);
            chk({6'h0, pe}, {6'h0, v[7:6]});
        end
        bus(1'b1, imc_pkg::IDX_PORT_DIR, 8'h00);
        bus(1'b1, 8'hE5, 8'h5A);
        bus(1'b0, 8'hE5, 8'h00);
        chk(rd, 8'h00);
        bus(1'b1, imc_pkg::IDX_DIVIDER, 8'h03);
        bus(1'b1, imc_pkg::IDX_OWN_ADDR, 8'h10);
        bus(1'b1, imc_pkg::IDX_CONTROL, 8'h80);
        bus(1'b1, imc_pkg::IDX_CONTROL, 8'hC0);
        bus(1'b0, imc_pkg::IDX_STATUS, 8'h00);
        chk(rd & 8'h20, 8'h00);
        // First pass calls a missing slave, second uses a repeated start
        for (int k = 0; k < 2; k++)
        begin
            nak = (k == 0) ? 8'h01 : 8'h00;
            bus(1'b1, imc_pkg::IDX_CONTROL, (k == 1) ? 8'hF4 : 8'hF0);
            bus(1'b1, imc_pkg::IDX_DATA, {SA ^ nak[6:0], k[0]});
            wait_st(imc_pkg::ST_BUSY, 1'b1);
            wait_st(imc_pkg::ST_IF, 1'b1);
            chk(rd, 8'hA2 | nak);
            chk({7'h0, irq}, 8'h01);
            bus(1'b0, imc_pkg::IDX_CONTROL, 8'h00);
            chk(rd, 8'hF0);
            bus(1'b1, imc_pkg::IDX_STATUS, 8'h02);
            bus(1'b0, imc_pkg::IDX_STATUS, 8'h00);
            chk(rd, 8'hA0 | nak);
            chk({7'h0, irq}, 8'h00);
        end
        // Read requested above: receive one byte with no-ack, stop before reading it
        bus(1'b1, imc_pkg::IDX_CONTROL, 8'hE8);
        bus(1'b0, imc_pkg::IDX_DATA, 8'h00);
        wait_st(imc_pkg::ST_IF, 1'b1);
        chk(rd, 8'hA3);
        bus(1'b1, imc_pkg::IDX_STATUS, 8'h02);
        bus(1'b1, imc_pkg::IDX_CONTROL, 8'hC0);
        bus(1'b0, imc_pkg::IDX_DATA, 8'h00);
        chk(rd, 8'hFF);
        wait_st(imc_pkg::ST_BUSY, 1'b0);
        chk(rd, 8'h01);
        stop_test();
    end
endmodule
